/* File: lrp_loopback_regport.sv */
// Function
// - Beat moves only when valid and ready
// - Accepted beats form 128-byte groups
// - Last beat pads group with 0xA5
// - Ready stays low while padding
// - Four return path settings exist
// - Mode codes: off, user, T2, T3
// - T2/T3 carry records, user carries bytes
// - Internal FIFO drained to host, may overflow
// - Fill reported as 16-bit ratio
// - Fill valid only with new-flags strobe
// - Link health record always presented
// - 32-bit data, 2^31 word addresses
// - Write: address and data, then strobe
// - Address may be held over cycles
// - Read: address with read strobe
// - Command flag selects read or write
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module lrp_loopback_regport #(
    parameter int DEPTH = 512, // Loopback FIFO words, power of two
    parameter int TIMEOUT_CYC = lrp_pkg::CMD_TIMEOUT_CYC, // Read answer limit
    parameter int FILL_PERIOD = lrp_pkg::FILL_PERIOD_CYC // Fill report spacing
) (
    input wire logic pclk, // 250 MHz clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic lb_tvalid, // User stream valid
    input wire lrp_pkg::lrp_beat_t lb_beat, // User stream data and last
    output logic lb_tready, // User stream ready
    input wire logic rec_wr, // Returned time-tag record valid
    input wire logic [31:0] rec_data, // Returned time-tag record
    output logic [1:0] return_path_mode, // Loopback setting
    output logic [15:0] fifo_fill_level, // Fill ratio
    output logic fifo_new_flags, // Fill ratio strobe
    input wire lrp_pkg::lrp_links_t link_state_in, // Raw link flags
    output lrp_pkg::lrp_links_t serial_links_health, // Link health record
    output lrp_pkg::lrp_reg_port_t user_reg, // Register port to user
    input wire logic [31:0] user_reg_rdata, // Read answer data
    input wire logic user_reg_rd_ready // Read answer strobe
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int TW = $clog2(TIMEOUT_CYC + 1);
    localparam int FW = $clog2(FILL_PERIOD + 1);
    localparam logic [4:0] LAST_BEAT = 5'(lrp_pkg::GROUP_BEATS - 1);
    localparam logic [CW-1:0] READY_ROOM = CW'(DEPTH - 2);

    typedef enum logic {PK_COLLECT, PK_PAD} lrp_pack_t;
    typedef enum logic [1:0] {RP_IDLE, RP_WSETUP, RP_WSTROBE, RP_RWAIT} lrp_cmd_t;

    lrp_pack_t pk_state; // Grouping state
    lrp_cmd_t cmd_state; // Register command state
    logic [4:0] beat_cnt; // Words in current group
    logic [1:0] next_mode; // Mode after this edge
    logic lb_accept; // Beat taken
    logic go_pad; // Early last seen
    logic rec_take; // Record offered to FIFO
    logic fifo_wr_valid; // Word offered to FIFO
    logic [31:0] fifo_wr_data; // Word into FIFO
    logic fifo_wr_ready; // FIFO has room
    logic fifo_rd_valid; // FIFO not empty
    logic [31:0] fifo_rd_data; // FIFO head
    logic fifo_pop; // Host read pops
    logic [CW-1:0] fifo_count; // FIFO words
    logic [31:0] ratio32; // Scaled fill
    logic [FW-1:0] fill_cnt; // Report period counter
    logic [TW-1:0] tmo_cnt; // Read wait counter
    logic ovf; // Sticky overflow
    logic tmo; // Sticky timeout
    logic done; // Sticky done
    logic [30:0] cmd_addr; // Staged word address
    logic [31:0] cmd_wdata; // Staged write data
    logic [31:0] cmd_rdata; // Last read answer
    logic apb_setup; // Access cycle before answer
    logic apb_done; // Transfer completes this edge
    logic wr_ctrl; // CTRL written
    logic wr_status; // STATUS written
    logic go_cmd; // Command start accepted
    logic mapped; // Address decodes

    // APB completes on the second access cycle
    assign apb_setup = psel & penable & ~pready;
    assign apb_done = psel & penable & pready;
    assign wr_ctrl = apb_done & pwrite & (paddr == lrp_pkg::ADDR_CTRL);
    assign wr_status = apb_done & pwrite & (paddr == lrp_pkg::ADDR_STATUS);
    // Busy port ignores a second start
    assign go_cmd = apb_done & pwrite & (paddr == lrp_pkg::ADDR_CMD_GO) & (cmd_state == RP_IDLE);
    assign fifo_pop = apb_done & ~pwrite & (paddr == lrp_pkg::ADDR_FIFO) & fifo_rd_valid;
    assign next_mode = wr_ctrl ? pwdata[1:0] : return_path_mode;

    // Address decode for the error answer
    always_comb begin
        case (paddr)
            lrp_pkg::ADDR_CTRL, lrp_pkg::ADDR_STATUS, lrp_pkg::ADDR_FIFO,
            lrp_pkg::ADDR_CMD_ADDR, lrp_pkg::ADDR_CMD_WDATA, lrp_pkg::ADDR_CMD_GO,
            lrp_pkg::ADDR_CMD_RDATA, lrp_pkg::ADDR_LINKS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Stream and record paths into the FIFO
    assign lb_accept = lb_tvalid & lb_tready;
    assign go_pad = lb_accept & lb_beat.last & (beat_cnt != LAST_BEAT);
    assign rec_take = rec_wr & ((return_path_mode == lrp_pkg::MODE_T2)
        | (return_path_mode == lrp_pkg::MODE_T3));
    assign fifo_wr_valid = lb_accept | (pk_state == PK_PAD) | rec_take;
    assign fifo_wr_data = (pk_state == PK_PAD) ? lrp_pkg::PAD_WORD :
        (rec_take ? rec_data : lb_beat.data);

    lrp_word_fifo #(
        .WIDTH(32),
        .DEPTH(DEPTH),
        .CW(CW)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .wr_valid(fifo_wr_valid),
        .wr_data(fifo_wr_data),
        .wr_ready(fifo_wr_ready),
        .rd_ready(fifo_pop),
        .rd_valid(fifo_rd_valid),
        .rd_data(fifo_rd_data),
        .count(fifo_count)
    );

    // Mode register, seen by the user as a plain output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            return_path_mode <= lrp_pkg::MODE_RESET;
        end else begin
            return_path_mode <= next_mode;
        end
    end

    // Ready is registered, so it looks two words ahead at FIFO room
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lb_tready <= 1'b0;
        end else begin
            lb_tready <= (next_mode == lrp_pkg::MODE_USER)
                & (pk_state == PK_COLLECT) & ~go_pad
                & (fifo_count < READY_ROOM);
        end
    end

    // Grouping of words into fixed groups
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pk_state <= PK_COLLECT;
            beat_cnt <= 5'h00;
        end else begin
            case (pk_state)
                PK_COLLECT: begin
                    if (lb_accept) begin
                        beat_cnt <= (beat_cnt == LAST_BEAT) ? 5'h00 : beat_cnt + 5'h01;
                        if (go_pad) begin
                            pk_state <= PK_PAD;
                        end
                    end
                end
                PK_PAD: begin
                    // Pad word waits for room, never dropped
                    if (fifo_wr_ready) begin
                        if (beat_cnt == LAST_BEAT) begin
                            beat_cnt <= 5'h00;
                            pk_state <= PK_COLLECT;
                        end else begin
                            beat_cnt <= beat_cnt + 5'h01;
                        end
                    end
                end
                default: begin
                    pk_state <= PK_COLLECT;
                end
            endcase
        end
    end

    // Overflow: records cannot be stalled, so a full FIFO loses them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf <= 1'b0;
        end else if (rec_take && !fifo_wr_ready) begin
            ovf <= 1'b1;
        end else if (wr_status && pwdata[lrp_pkg::STAT_OVF_BIT]) begin
            ovf <= 1'b0;
        end
    end

    // Fill ratio, full reads as all ones
    assign ratio32 = (32'(fifo_count) * 32'h0000_ffff) / 32'(DEPTH);

    // Periodic fill report with its strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_cnt <= '0;
            fifo_new_flags <= 1'b0;
            fifo_fill_level <= 16'h0000;
        end else if (fill_cnt == FW'(FILL_PERIOD - 1)) begin
            fill_cnt <= '0;
            fifo_new_flags <= 1'b1;
            fifo_fill_level <= ratio32[15:0];
        end else begin
            fill_cnt <= fill_cnt + 1'b1;
            fifo_new_flags <= 1'b0;
        end
    end

    // Link health, registered every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_links_health <= '0;
        end else begin
            serial_links_health <= link_state_in;
        end
    end

    // Staged command words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_addr <= 31'h0000_0000;
            cmd_wdata <= 32'h0000_0000;
        end else if (apb_done && pwrite) begin
            if (paddr == lrp_pkg::ADDR_CMD_ADDR) begin
                cmd_addr <= pwdata[30:0];
            end
            if (paddr == lrp_pkg::ADDR_CMD_WDATA) begin
                cmd_wdata <= pwdata;
            end
        end
    end

    // Register port sequencer; address stays after the strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_state <= RP_IDLE;
            user_reg <= '0;
            tmo_cnt <= '0;
            cmd_rdata <= 32'h0000_0000;
        end else begin
            case (cmd_state)
                RP_IDLE: begin
                    if (go_cmd) begin
                        user_reg.addr <= {1'b0, cmd_addr};
                        tmo_cnt <= '0;
                        if (pwdata[lrp_pkg::GO_WRITE_BIT]) begin
                            user_reg.wdata <= cmd_wdata;
                            cmd_state <= RP_WSETUP;
                        end else begin
                            user_reg.rd <= 1'b1;
                            cmd_state <= RP_RWAIT;
                        end
                    end
                end
                RP_WSETUP: begin
                    user_reg.wr <= 1'b1;
                    cmd_state <= RP_WSTROBE;
                end
                RP_WSTROBE: begin
                    user_reg.wr <= 1'b0;
                    cmd_state <= RP_IDLE;
                end
                RP_RWAIT: begin
                    user_reg.rd <= 1'b0;
                    // Only the first ready of a read counts
                    if (user_reg_rd_ready) begin
                        cmd_rdata <= user_reg_rdata;
                        cmd_state <= RP_IDLE;
                    end else if (tmo_cnt == TW'(TIMEOUT_CYC - 1)) begin
                        cmd_state <= RP_IDLE;
                    end else begin
                        tmo_cnt <= tmo_cnt + 1'b1;
                    end
                end
                default: begin
                    cmd_state <= RP_IDLE;
                end
            endcase
        end
    end

    // Sticky done and timeout; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
            tmo <= 1'b0;
        end else begin
            if (cmd_state == RP_WSTROBE || (cmd_state == RP_RWAIT && user_reg_rd_ready)) begin
                done <= 1'b1;
            end else if (wr_status && pwdata[lrp_pkg::STAT_DONE_BIT]) begin
                done <= 1'b0;
            end
            if (cmd_state == RP_RWAIT && !user_reg_rd_ready
                && tmo_cnt == TW'(TIMEOUT_CYC - 1)) begin
                tmo <= 1'b1;
            end else if (wr_status && pwdata[lrp_pkg::STAT_TMO_BIT]) begin
                tmo <= 1'b0;
            end
        end
    end

    // APB answer: one wait cycle, data and error registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~mapped;
            if (apb_setup && !pwrite) begin
                case (paddr)
                    lrp_pkg::ADDR_CTRL: prdata <= {30'h0000_0000, return_path_mode};
                    lrp_pkg::ADDR_STATUS: begin
                        prdata <= 32'h0000_0000;
                        prdata[lrp_pkg::STAT_OVF_BIT] <= ovf;
                        prdata[lrp_pkg::STAT_BUSY_BIT] <= cmd_state != RP_IDLE;
                        prdata[lrp_pkg::STAT_TMO_BIT] <= tmo;
                        prdata[lrp_pkg::STAT_DONE_BIT] <= done;
                        prdata[lrp_pkg::STAT_EMPTY_BIT] <= ~fifo_rd_valid;
                        prdata[lrp_pkg::STAT_FILL_LSB +: 16] <= ratio32[15:0];
                    end
                    lrp_pkg::ADDR_FIFO: prdata <= fifo_rd_valid ? fifo_rd_data : 32'h0000_0000;
                    lrp_pkg::ADDR_CMD_ADDR: prdata <= {1'b0, cmd_addr};
                    lrp_pkg::ADDR_CMD_WDATA: prdata <= cmd_wdata;
                    lrp_pkg::ADDR_CMD_RDATA: prdata <= cmd_rdata;
                    lrp_pkg::ADDR_LINKS: begin
                        prdata <= 32'h0000_0000;
                        prdata[lrp_pkg::NUM_LINKS-1:0] <= serial_links_health.up;
                        prdata[lrp_pkg::LINKS_ERR_LSB +: lrp_pkg::NUM_LINKS] <=
                            serial_links_health.err;
                    end
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Checks
    property p_ready_mode;
        @(posedge pclk) disable iff (!presetn) lb_tready |-> return_path_mode == lrp_pkg::MODE_USER;
    endproperty
    a_ready_mode: assert property (p_ready_mode) else $error("ready outside user mode");

    property p_pad_stall;
        @(posedge pclk) disable iff (!presetn) pk_state == PK_PAD |-> !lb_tready;
    endproperty
    a_pad_stall: assert property (p_pad_stall) else $error("ready while padding");

    property p_last_pads;
        @(posedge pclk) disable iff (!presetn) go_pad |=> pk_state == PK_PAD ##0 !lb_tready;
    endproperty
    a_last_pads: assert property (p_last_pads) else $error("early last not padded");

    property p_pad_word;
        @(posedge pclk) disable iff (!presetn)
            pk_state == PK_PAD |-> fifo_wr_data == lrp_pkg::PAD_WORD && !lb_accept;
    endproperty
    a_pad_word: assert property (p_pad_word) else $error("pad word wrong");

    property p_group_wrap;
        @(posedge pclk) disable iff (!presetn)
            (lb_accept || (pk_state == PK_PAD && fifo_wr_ready)) && beat_cnt == LAST_BEAT
            |=> beat_cnt == 5'h00 && pk_state == PK_COLLECT;
    endproperty
    a_group_wrap: assert property (p_group_wrap) else $error("group not 128 bytes");

    property p_write_seq;
        @(posedge pclk) disable iff (!presetn)
            $rose(user_reg.wr) |-> $stable(user_reg.addr) && $stable(user_reg.wdata)
            ##1 !user_reg.wr && $stable(user_reg.addr);
    endproperty
    a_write_seq: assert property (p_write_seq) else $error("write strobe sequence");

    property p_read_pulse;
        @(posedge pclk) disable iff (!presetn)
            user_reg.rd |-> !user_reg.wr ##1 !user_reg.rd && cmd_state != RP_WSETUP;
    endproperty
    a_read_pulse: assert property (p_read_pulse) else $error("read strobe not a pulse");

    property p_read_capture;
        @(posedge pclk) disable iff (!presetn)
            cmd_state == RP_RWAIT && user_reg_rd_ready
            |=> cmd_rdata == $past(user_reg_rdata) && cmd_state == RP_IDLE && done;
    endproperty
    a_read_capture: assert property (p_read_capture) else $error("read answer lost");

    property p_fill_strobe;
        @(posedge pclk) disable iff (!presetn)
            fifo_new_flags |-> fifo_fill_level == $past(ratio32[15:0]) ##1 !fifo_new_flags;
    endproperty
    a_fill_strobe: assert property (p_fill_strobe) else $error("fill report wrong");

    property p_overflow;
        @(posedge pclk) disable iff (!presetn) rec_take && !fifo_wr_ready |=> ovf;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");
endmodule
`default_nettype wire

/* File: lrp_loopback_regport_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module lrp_loopback_regport_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lb_tvalid = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat, r, a, d[3];
    logic pready, pslverr, lb_tready, fnf, e, rd_ready;
    logic [1:0] mode;
    logic [15:0] fill;
    logic [2:0] lag = 0;
    logic rec_wr = 0;
    logic [31:0] rec_data = 0;
    lrp_pkg::lrp_beat_t lb_beat = 0;
    lrp_pkg::lrp_links_t lin = 0, lout;
    lrp_pkg::lrp_reg_port_t ureg;
    int bad_count = 0, checks = 0, cyc = 0, wrs = 0, n;
    always #2 pclk = ~pclk;
    lrp_loopback_regport #(.DEPTH(64), .TIMEOUT_CYC(20), .FILL_PERIOD(8)) uut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lb_tvalid(lb_tvalid), .lb_beat(lb_beat), .lb_tready(lb_tready), .rec_wr(rec_wr),
        .rec_data(rec_data), .return_path_mode(mode), .fifo_fill_level(fill),
        .fifo_new_flags(fnf), .link_state_in(lin), .serial_links_health(lout),
        .user_reg(ureg), .user_reg_rdata(rdat), .user_reg_rd_ready(rd_ready));
    lrp_user_model um (.pclk(pclk), .rd(ureg.rd), .addr(ureg.addr), .lag(lag), .rdata(rdat),
        .rd_ready(rd_ready));
    task automatic stop_test;
        if (bad_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is sampled
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        n = 0;
        psel <= 1; pwrite <= w; paddr <= ad; pwdata <= wd; penable <= 0;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    function automatic logic [15:0] ratio(input int words);
        return 16'(words * 65535 / 64);
    endfunction
    // Count write strobes and keep the address they carried
    always @(posedge pclk) if (ureg.wr === 1'b1) begin
        wrs++;
        a = ureg.addr;
    end
    always @(posedge pclk) if (++cyc == 20000) begin
        bad_count++;
        stop_test;
    end
    initial begin
        void'($urandom(32'h51d3));
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk(lb_tready, 0);
        for (int m = 3; m >= 0; m--) begin
            apb(1, lrp_pkg::ADDR_CTRL, m);
            apb(0, lrp_pkg::ADDR_CTRL, 0);
            chk({r[1:0], mode, 1'(m == 1 || lb_tready === 1'b0)}, {2'(m), 2'(m), 1'b1});
        end
        apb(1, lrp_pkg::ADDR_CTRL, 1);
        foreach (d[i]) begin // Three beats keep a wide FIFO margin
            d[i] = $urandom;
            lb_tvalid <= 1; lb_beat <= {d[i], 1'(i == 2)};
            n = 0;
            do @(posedge pclk); while (lb_tready !== 1'b1 && ++n < 50);
        end
        lb_tvalid <= 0;
        repeat (2) @(posedge pclk);
        chk(lb_tready, 0);
        n = 0;
        while (lb_tready !== 1'b1 && ++n < 100) @(posedge pclk);
        while (fnf !== 1'b1 && ++n < 200) @(posedge pclk);
        chk(fill, ratio(32));
        for (int i = 0; i < 32; i++) begin
            apb(0, lrp_pkg::ADDR_FIFO, 0);
            chk(r, i < 3 ? d[i] : lrp_pkg::PAD_WORD);
        end
        apb(0, lrp_pkg::ADDR_STATUS, 0);
        chk(r[lrp_pkg::STAT_EMPTY_BIT], 1);
        apb(0, 8'h40, 0);
        chk(e, 1);
        chk(r, 0);
        d[0] = $urandom;
        apb(1, lrp_pkg::ADDR_CMD_ADDR, d[0]);
        apb(1, lrp_pkg::ADDR_CMD_WDATA, d[1]);
        apb(1, lrp_pkg::ADDR_CMD_GO, 1);
        repeat (4) @(posedge pclk);
        chk(a, {1'b0, d[0][30:0]});
        chk(ureg.wdata, d[1]);
        chk(wrs, 1);
        lag <= 3'($urandom);
        apb(1, lrp_pkg::ADDR_CMD_GO, 0);
        repeat (12) @(posedge pclk);
        apb(0, lrp_pkg::ADDR_CMD_RDATA, 0);
        chk(r, ~{1'b0, d[0][30:0]});
        // Records in T2 mode overrun the 64-word FIFO on purpose
        apb(1, lrp_pkg::ADDR_CTRL, 2);
        for (int i = 0; i < 66; i++) begin
            rec_wr <= 1;
            rec_data <= (i == 0) ? d[2] : $urandom;
            @(posedge pclk);
        end
        rec_wr <= 0;
        apb(0, lrp_pkg::ADDR_STATUS, 0);
        chk(r[lrp_pkg::STAT_OVF_BIT], 1);
        n = 0;
        while (fnf !== 1'b1 && ++n < 20) @(posedge pclk);
        chk(fill, 16'hffff);
        apb(0, lrp_pkg::ADDR_FIFO, 0);
        chk(r, d[2]);
        lin <= lrp_pkg::lrp_links_t'($urandom);
        repeat (3) @(posedge pclk);
        chk(32'(lout), 32'(lin));
        stop_test;
    end
endmodule
`default_nettype wire

/* File: lrp_loopback_regport_note_end.sv */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* File: lrp_pkg.sv */
`default_nettype none
package lrp_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_PS = 4000; // 250 MHz pclk
    localparam int CMD_TIMEOUT_NS = 10000; // Longest wait for a read answer
    localparam int CMD_TIMEOUT_CYC = (CMD_TIMEOUT_NS * 1000) / CLK_PERIOD_PS; // Rounded down
    localparam int FILL_PERIOD_NS = 1024; // Spacing of fill reports
    localparam int FILL_PERIOD_CYC = (FILL_PERIOD_NS * 1000) / CLK_PERIOD_PS;

    // Loopback grouping
    localparam int GROUP_BYTES = 128; // Bytes per forwarded group
    localparam int BEAT_BYTES = 4; // Bytes per 32-bit beat
    localparam int GROUP_BEATS = GROUP_BYTES / BEAT_BYTES;
    localparam logic [7:0] PAD_BYTE = 8'ha5; // Fill byte after an early last
    localparam logic [31:0] PAD_WORD = {4{PAD_BYTE}};
    localparam int NUM_LINKS = 9; // Serial links reported

    // Return path mode codes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_USER = 2'h1;
    localparam logic [1:0] MODE_T2 = 2'h2;
    localparam logic [1:0] MODE_T3 = 2'h3;
    localparam logic [1:0] MODE_RESET = 2'h0;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_FIFO = 8'h08;
    localparam logic [7:0] ADDR_CMD_ADDR = 8'h0c;
    localparam logic [7:0] ADDR_CMD_WDATA = 8'h10;
    localparam logic [7:0] ADDR_CMD_GO = 8'h14;
    localparam logic [7:0] ADDR_CMD_RDATA = 8'h18;
    localparam logic [7:0] ADDR_LINKS = 8'h1c;

    // Field positions
    localparam int STAT_OVF_BIT = 0; // Sticky FIFO overflow, write one to clear
    localparam int STAT_BUSY_BIT = 1; // Register command in progress
    localparam int STAT_TMO_BIT = 2; // Sticky read timeout, write one to clear
    localparam int STAT_DONE_BIT = 3; // Sticky command done, write one to clear
    localparam int STAT_EMPTY_BIT = 4; // Loopback FIFO empty
    localparam int STAT_FILL_LSB = 16; // Current fill ratio
    localparam int GO_WRITE_BIT = 0; // 0 read, 1 write
    localparam int LINKS_ERR_LSB = 16; // Error bits in link word

    // Stream beat from user logic
    typedef struct packed {
        logic [31:0] data;
        logic last;
    } lrp_beat_t;

    // Register port toward user logic
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lrp_reg_port_t;

    // Per-link health flags
    typedef struct packed {
        logic [NUM_LINKS-1:0] up;
        logic [NUM_LINKS-1:0] err;
    } lrp_links_t;
endpackage
`default_nettype wire

/* File: lrp_user_model.sv */
`timescale 1ns/10ps
`default_nettype none
module lrp_user_model (
    input wire logic pclk, // Clock
    input wire logic rd, // Read strobe
    input wire logic [31:0] addr, // Read address
    input wire logic [2:0] lag, // Answer delay
    output logic [31:0] rdata, // Answer data
    output logic rd_ready // Answer strobe
);
    logic [2:0] cnt; // Cycles left
    logic owed; // Answer pending
    initial begin
        owed = 0;
        cnt = 0;
        rdata = 0;
        rd_ready = 0;
    end
    // Answer each read once; data toggles when not valid
    always @(posedge pclk) begin
        rd_ready <= 0;
        rdata <= ~rdata;
        if (rd) begin
            owed <= 1;
            cnt <= lag;
        end else if (owed && cnt == 0) begin
            owed <= 0;
            rd_ready <= 1;
            rdata <= ~addr;
        end else if (owed) begin
            cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

/* File: lrp_word_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module lrp_word_fifo #(
    parameter int WIDTH = 32, // Word width
    parameter int DEPTH = 512, // Words, power of two
    parameter int CW = $clog2(DEPTH + 1) // Count width
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Async reset, active low
    input wire logic wr_valid, // Write request
    input wire logic [WIDTH-1:0] wr_data, // Write word
    output logic wr_ready, // Room for a word
    input wire logic rd_ready, // Pop request
    output logic rd_valid, // Head word present
    output logic [WIDTH-1:0] rd_data, // Head word
    output logic [CW-1:0] count // Words held
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH]; // Storage flops
    logic [AW-1:0] wr_ptr; // Next slot to fill
    logic [AW-1:0] rd_ptr; // Head slot
    logic push; // Word enters
    logic pop; // Word leaves

    assign wr_ready = count != CW'(DEPTH);
    assign rd_valid = count != '0;
    assign rd_data = mem[rd_ptr];
    assign push = wr_valid & wr_ready;
    assign pop = rd_ready & rd_valid;

    // Storage needs no reset; count guards every read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= wr_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire
